// File: hdl/etm_top.sv
// Compare match timer: register port, flags, interrupt, two output pins.
// Assumes a synchronous register master on i_clk (100 MHz).
// Contract
// [RQ1] Level select sets pin before first match
// [RQ2] Invert bit inverts channel B pin
// [RQ3] Timer/counter mode ignores level and invert
// [RQ4] Alignment field: edge, up, down, both
// [RQ5] Period compares upper counter byte only
// [RQ6] Zero period runs to overflow
// [RQ7] Period match clears only when select low
// [RQ8] Software sets both channel modes equal
// [RQ9] Both modes zero selects compare output
// [RQ10] Select low: period clear, A and P flags
// [RQ11] Select high: A clears, no P flag
// [RQ12] Pins change only on A/B matches
// [RQ13] Each pin follows its own function field
// [RQ14] Run rising edge loads initial pin levels
// [RQ15] Function zero leaves pin unchanged
// [RQ16] All mode bits high: no pin driven
// [RQ17] Function codes: hold, low, high, toggle
// [RQ18] Clear select: 0 period, 1 comparator A
// [RQ19] 16-bit counter, full 16-bit comparators A/B
//
// The address-and-strobe port and the register addresses were left to the implementer.
`timescale 1ns/1ps
module etm_top
	import etm_pkg::*;
(
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rstn,
	// Register port
	input wire logic [AW-1:0] i_addr,
	input wire logic [DW-1:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [DW-1:0] o_rdata,
	// Interrupt
	output logic o_irq,
	// Output pins
	output logic o_pin_a,
	output logic o_pin_a_oe_n,
	output logic o_pin_b,
	output logic o_pin_b_oe_n
);
	function automatic etm_mode_t mode_of(input logic [DW-1:0] ctl);
		return etm_mode_t'(ctl[F_MODE +: 2]);
	endfunction

	function automatic logic [3:0] align_dec(input logic [1:0] f);
		etm_align_t a;
		a = etm_align_t'(f);
		case (a) // [RQ4]
			AL_EDGE: align_dec = 4'h1;
			AL_UP: align_dec = 4'h2;
			AL_DOWN: align_dec = 4'h4;
			AL_BOTH: align_dec = 4'h6;
			default: align_dec = 4'h0;
		endcase
	endfunction

	etm_cnt_if lnk ();

	logic [DW-1:0] ctl1_r;
	logic [DW-1:0] ctl2_r;
	logic [7:0] prd_r;
	logic [CW-1:0] cmpa_r;
	logic [CW-1:0] cmpb_r;
	logic run_r;
	logic run_prev_r;
	logic [2:0] stat_r;
	logic [2:0] stat_nxt;
	logic [2:0] mask_r;
	logic [DW-1:0] rd_val;

	// Address decode
	wire logic wr_ctl1 = i_wr && (i_addr == OFS_CTL1);
	wire logic wr_ctl2 = i_wr && (i_addr == OFS_CTL2);
	wire logic wr_prd = i_wr && (i_addr == OFS_PRD);
	wire logic wr_cal = i_wr && (i_addr == OFS_CMPA_L);
	wire logic wr_cah = i_wr && (i_addr == OFS_CMPA_H);
	wire logic wr_cbl = i_wr && (i_addr == OFS_CMPB_L);
	wire logic wr_cbh = i_wr && (i_addr == OFS_CMPB_H);
	wire logic wr_run = i_wr && (i_addr == OFS_RUN);
	wire logic wr_stat = i_wr && (i_addr == OFS_STAT);
	wire logic wr_mask = i_wr && (i_addr == OFS_MASK);

	// Mode decode; mixed channel modes are left inert
	wire etm_mode_t mode_a = mode_of(ctl1_r);
	wire etm_mode_t mode_b = mode_of(ctl2_r);
	wire logic cmp_mode = (mode_a == MODE_CMP)
		&& (mode_b == MODE_CMP); // [RQ9] [RQ8]
	wire logic tc_mode = (mode_a == MODE_TC)
		&& (mode_b == MODE_TC); // [RQ16] [RQ8]
	wire logic flag_mode = cmp_mode || tc_mode; // [RQ16]
	wire logic run_rise = run_r && !run_prev_r; // [RQ14]
	wire logic [3:0] align_bits = align_dec(ctl2_r[F_ALN +: 2]);

	// Flag sources; setting wins over a same-cycle clear
	wire logic [2:0] ev;
	assign ev[S_A] = flag_mode && lnk.hit_a; // [RQ10] [RQ11]
	assign ev[S_B] = flag_mode && lnk.hit_b;
	assign ev[S_P] = flag_mode && lnk.hit_p; // [RQ10] [RQ11]
	assign stat_nxt = (stat_r & ~(wr_stat ? i_wdata[2:0] : 3'h0)) | ev;

	// Link to counter core
	assign lnk.run = run_r;
	assign lnk.clr_sel = ctl1_r[F_CLR]; // [RQ18]
	assign lnk.period = prd_r; // [RQ5]
	assign lnk.cmp_a = cmpa_r;
	assign lnk.cmp_b = cmpb_r;

	// Read mux; count direction reads as zero (count up only)
	always_comb
	begin
		case (i_addr)
			OFS_CTL1: rd_val = ctl1_r;
			OFS_CTL2: rd_val = ctl2_r;
			OFS_PRD: rd_val = prd_r;
			OFS_CMPA_L: rd_val = cmpa_r[7:0];
			OFS_CMPA_H: rd_val = cmpa_r[15:8];
			OFS_CMPB_L: rd_val = cmpb_r[7:0];
			OFS_CMPB_H: rd_val = cmpb_r[15:8];
			OFS_RUN: rd_val = {7'h00, run_r};
			OFS_CNT_L: rd_val = lnk.cnt[7:0];
			OFS_CNT_H: rd_val = lnk.cnt[15:8];
			OFS_STAT: rd_val = {5'h00, stat_r};
			OFS_MASK: rd_val = {5'h00, mask_r};
			OFS_ALIGN: rd_val = {4'h0, align_bits};
			default: rd_val = RST_BYTE;
		endcase
	end

	etm_counter u_counter (
		.i_clk(i_clk),
		.i_rstn(i_rstn),
		.lnk(lnk.core)
	);

	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			ctl1_r <= RST_BYTE;
			ctl2_r <= RST_BYTE;
			prd_r <= RST_BYTE;
		end
		else
		begin
			if (wr_ctl1)
				ctl1_r <= i_wdata & ~(8'h01 << F_DIR);
			if (wr_ctl2)
				ctl2_r <= i_wdata;
			if (wr_prd)
				prd_r <= i_wdata;
		end
	end

	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			cmpa_r <= '0;
			cmpb_r <= '0;
		end
		else
		begin
			if (wr_cal)
				cmpa_r[7:0] <= i_wdata;
			if (wr_cah)
				cmpa_r[15:8] <= i_wdata;
			if (wr_cbl)
				cmpb_r[7:0] <= i_wdata;
			if (wr_cbh)
				cmpb_r[15:8] <= i_wdata;
		end
	end

	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			run_r <= 1'b0;
			run_prev_r <= 1'b0;
			stat_r <= 3'h0;
			mask_r <= 3'h0;
		end
		else
		begin
			if (wr_run)
				run_r <= i_wdata[0];
			run_prev_r <= run_r;
			stat_r <= stat_nxt;
			if (wr_mask)
				mask_r <= i_wdata[2:0];
		end
	end

	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			o_rdata <= RST_BYTE;
			o_irq <= 1'b0;
		end
		else
		begin
			o_rdata <= i_rd ? rd_val : RST_BYTE;
			o_irq <= |(stat_nxt & mask_r);
		end
	end

	// Pin channels: A uses control one, B control two
	wire logic [1:0] p_lvl = {ctl2_r[F_LVL], ctl1_r[F_LVL]};
	wire logic [1:0] p_inv = {ctl2_r[F_INV], ctl1_r[F_INV]};
	wire logic [1:0] p_hit = {lnk.hit_b, lnk.hit_a}; // [RQ12]
	wire logic [3:0] p_fn = {ctl2_r[F_FUNC +: 2], ctl1_r[F_FUNC +: 2]};
	wire logic [1:0] p_out;
	wire logic [1:0] p_oe_n;

	genvar g;
	generate
		for (g = 0; g < 2; g++)
		begin : g_pin
			etm_outpin u_pin (
				.i_clk(i_clk),
				.i_rstn(i_rstn),
				.i_load(run_rise),
				.i_level_sel(p_lvl[g]), // [RQ1]
				.i_match(p_hit[g]), // [RQ13]
				.i_func(p_fn[2*g +: 2]),
				.i_invert(p_inv[g]), // [RQ2]
				.i_drive(cmp_mode), // [RQ3] [RQ16]
				.o_pin(p_out[g]),
				.o_oe_n(p_oe_n[g])
			);
		end
	endgenerate

	assign o_pin_a = p_out[0];
	assign o_pin_b = p_out[1];
	assign o_pin_a_oe_n = p_oe_n[0];
	assign o_pin_b_oe_n = p_oe_n[1];

	AST_A_FLAG: assert property ( // [RQ10]
		@(posedge i_clk) disable iff (!i_rstn)
		flag_mode && lnk.hit_a |=> stat_r[S_A])
		else $error("comparator A match lost");

	AST_B_FLAG: assert property ( // [RQ16]
		@(posedge i_clk) disable iff (!i_rstn)
		tc_mode && lnk.hit_b |=> stat_r[S_B])
		else $error("comparator B match lost in timer mode");

	AST_NO_FLAG_INERT: assert property ( // [RQ9]
		@(posedge i_clk) disable iff (!i_rstn)
		!flag_mode && !stat_r[S_A] |=> !stat_r[S_A])
		else $error("flag raised outside the flag modes");

	AST_NO_P_SEL1: assert property ( // [RQ11]
		@(posedge i_clk) disable iff (!i_rstn)
		ctl1_r[F_CLR] && !(wr_stat && i_wdata[S_P]) && !stat_r[S_P]
		|=> !stat_r[S_P])
		else $error("period flag raised with clear select high");

	AST_P_FLAG: assert property ( // [RQ10]
		@(posedge i_clk) disable iff (!i_rstn)
		flag_mode && lnk.prd_hit && !ctl1_r[F_CLR] |=> stat_r[S_P])
		else $error("period flag missing");

	AST_PRD_LOW_BYTE: assert property ( // [RQ5]
		@(posedge i_clk) disable iff (!i_rstn)
		lnk.prd_hit && prd_r != PRD_LOW |-> lnk.cnt[7:0] == 8'hFF)
		else $error("period match off the coarse boundary");

	AST_A_CLEAR: assert property ( // [RQ11]
		@(posedge i_clk) disable iff (!i_rstn)
		ctl1_r[F_CLR] && lnk.hit_a |=> lnk.cnt == 16'h0000)
		else $error("comparator A match did not clear counter");

	// Mode must have been steady, or the enable step moves the pin
	AST_P_NO_PIN: assert property ( // [RQ12]
		@(posedge i_clk) disable iff (!i_rstn)
		cmp_mode && $past(cmp_mode) && !lnk.hit_a && !run_rise
		&& $stable(ctl1_r) ##1 cmp_mode |-> $stable(o_pin_a))
		else $error("pin A moved without its own match");

	AST_P_NO_PIN_B: assert property ( // [RQ12]
		@(posedge i_clk) disable iff (!i_rstn)
		cmp_mode && $past(cmp_mode) && !lnk.hit_b && !run_rise
		&& $stable(ctl2_r) ##1 cmp_mode |-> $stable(o_pin_b))
		else $error("pin B moved without its own match");

	AST_OE_CMP: assert property ( // [RQ9]
		@(posedge i_clk) disable iff (!i_rstn)
		cmp_mode |=> !o_pin_a_oe_n && !o_pin_b_oe_n)
		else $error("pin not driven in compare output mode");

	AST_TC_FREE: assert property ( // [RQ16] [RQ3]
		@(posedge i_clk) disable iff (!i_rstn)
		tc_mode
		|=> o_pin_a_oe_n && o_pin_b_oe_n && !o_pin_a && !o_pin_b)
		else $error("pin driven in timer/counter mode");

	AST_A_HIGH: assert property ( // [RQ17]
		@(posedge i_clk) disable iff (!i_rstn)
		cmp_mode && lnk.hit_a && !run_rise && p_fn[1:0] == 2'b10
		|=> o_pin_a == !$past(p_inv[0]))
		else $error("pin A not driven high on match");

	AST_B_LOW: assert property ( // [RQ17] [RQ2]
		@(posedge i_clk) disable iff (!i_rstn)
		cmp_mode && lnk.hit_b && !run_rise && p_fn[3:2] == 2'b01
		|=> o_pin_b == $past(p_inv[1]))
		else $error("pin B not driven low on match");

	AST_B_HIGH: assert property ( // [RQ17] [RQ2]
		@(posedge i_clk) disable iff (!i_rstn)
		cmp_mode && lnk.hit_b && !run_rise && p_fn[3:2] == 2'b10
		|=> o_pin_b == !$past(p_inv[1]))
		else $error("pin B not driven high on match");

	AST_A_TOGGLE: assert property ( // [RQ13]
		@(posedge i_clk) disable iff (!i_rstn)
		cmp_mode && $past(cmp_mode) && lnk.hit_a && !run_rise
		&& p_fn[1:0] == 2'b11 && $stable(ctl1_r)
		|=> o_pin_a != $past(o_pin_a))
		else $error("pin A did not toggle");

	AST_B_TOGGLE: assert property ( // [RQ13]
		@(posedge i_clk) disable iff (!i_rstn)
		cmp_mode && $past(cmp_mode) && lnk.hit_b && !run_rise
		&& p_fn[3:2] == 2'b11 && $stable(ctl2_r)
		|=> o_pin_b != $past(o_pin_b))
		else $error("pin B did not toggle");

	AST_RUN_COUNT: assert property ( // [RQ19]
		@(posedge i_clk) disable iff (!i_rstn)
		run_r && !lnk.hit_a && !lnk.prd_hit && lnk.cnt != CNT_MAX
		|=> lnk.cnt == $past(lnk.cnt) + 16'h0001)
		else $error("counter did not advance");

	AST_OVF: assert property ( // [RQ6]
		@(posedge i_clk) disable iff (!i_rstn)
		run_r && prd_r == PRD_LOW && !ctl1_r[F_CLR] && lnk.cnt == CNT_MAX
		|=> lnk.cnt == 16'h0000)
		else $error("zero period did not wrap at overflow");

	AST_IRQ: assert property (
		@(posedge i_clk) disable iff (!i_rstn)
		ev[S_B] && mask_r[S_B] |=> o_irq)
		else $error("interrupt not raised for unmasked event");

	AST_STAT_W1C: assert property (
		@(posedge i_clk) disable iff (!i_rstn)
		wr_stat && i_wdata[S_A] && !ev[S_A] |=> !stat_r[S_A])
		else $error("status bit not cleared by writing one");

	AST_RD: assert property (
		@(posedge i_clk) disable iff (!i_rstn)
		!i_rd |=> o_rdata == 8'h00)
		else $error("read data outside read cycle");
endmodule // etm_top

// File: hdl/etm_pkg.sv
// Constants for the compare match timer: register offsets, fields, modes.
// Assumes an 8-bit register port with a 4-bit word address.
package etm_pkg;
	localparam int AW = 4;
	localparam int DW = 8;
	localparam int CW = 16;
	localparam logic [AW-1:0] OFS_CTL1 = 4'h0;
	localparam logic [AW-1:0] OFS_CTL2 = 4'h1;
	localparam logic [AW-1:0] OFS_PRD = 4'h2;
	localparam logic [AW-1:0] OFS_CMPA_L = 4'h3;
	localparam logic [AW-1:0] OFS_CMPA_H = 4'h4;
	localparam logic [AW-1:0] OFS_CMPB_L = 4'h5;
	localparam logic [AW-1:0] OFS_CMPB_H = 4'h6;
	localparam logic [AW-1:0] OFS_RUN = 4'h7;
	localparam logic [AW-1:0] OFS_CNT_L = 4'h8;
	localparam logic [AW-1:0] OFS_CNT_H = 4'h9;
	localparam logic [AW-1:0] OFS_STAT = 4'hA;
	localparam logic [AW-1:0] OFS_MASK = 4'hB;
	localparam logic [AW-1:0] OFS_ALIGN = 4'hC;
	localparam logic [DW-1:0] RST_BYTE = 8'h00;
	localparam logic [CW-1:0] CNT_MAX = 16'hFFFF;
	localparam logic [7:0] PRD_LOW = 8'h00;
	// Control byte fields; mode, function, level and invert are shared by both channel control registers
	localparam int F_MODE = 6;
	localparam int F_FUNC = 4;
	localparam int F_LVL = 3;
	localparam int F_INV = 2;
	localparam int F_DIR = 1;
	localparam int F_CLR = 0;
	localparam int F_ALN = 0;
	// Status and mask bit positions
	localparam int S_A = 0;
	localparam int S_B = 1;
	localparam int S_P = 2;
	typedef enum logic [1:0] {MODE_CMP, MODE_CAP, MODE_PWM, MODE_TC} etm_mode_t;
	typedef enum logic [1:0] {FN_HOLD, FN_LOW, FN_HIGH, FN_TOG} etm_func_t;
	typedef enum logic [1:0] {AL_EDGE, AL_UP, AL_DOWN, AL_BOTH} etm_align_t;
endpackage

// File: hdl/etm_cnt_if.sv
// Link between the register block and the counter/comparator core.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface etm_cnt_if;
	logic run;
	logic clr_sel;
	logic [7:0] period;
	logic [15:0] cmp_a;
	logic [15:0] cmp_b;
	logic [15:0] cnt;
	logic hit_a;
	logic hit_b;
	logic hit_p;
	logic prd_hit;
	modport core (input run, clr_sel, period, cmp_a, cmp_b,
		output cnt, hit_a, hit_b, hit_p, prd_hit);
	modport ctl (output run, clr_sel, period, cmp_a, cmp_b,
		input cnt, hit_a, hit_b, hit_p, prd_hit);
endinterface

// File: hdl/etm_counter.sv
// Counter core: 16-bit up-counter with comparators A, B and coarse P.
// Assumes configuration comes from logic on the same clock.
`timescale 1ns/1ps
module etm_counter
	import etm_pkg::*;
(
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rstn,
	// Core side of the link
	etm_cnt_if.core lnk
);
	logic [CW-1:0] cnt_r;
	logic [CW-1:0] cnt_nxt;
	wire logic [CW-1:0] cnt_inc = cnt_r + 16'h0001;
	wire logic prd_zero = (lnk.period == PRD_LOW);
	// Coarse match one count early so the period is exactly N x 256
	wire logic prd_eq = prd_zero ? (cnt_r == CNT_MAX)
		: (cnt_inc == {lnk.period, PRD_LOW}); // [RQ5] [RQ6]
	wire logic clear = lnk.clr_sel ? lnk.hit_a : lnk.prd_hit; // [RQ7] [RQ18]

	assign lnk.hit_a = lnk.run && (cnt_r == lnk.cmp_a); // [RQ19]
	assign lnk.hit_b = lnk.run && (cnt_r == lnk.cmp_b); // [RQ19]
	assign lnk.prd_hit = lnk.run && prd_eq;
	assign lnk.hit_p = lnk.prd_hit && !lnk.clr_sel; // [RQ11]
	assign lnk.cnt = cnt_r;
	assign cnt_nxt = !lnk.run ? cnt_r : (clear ? '0 : cnt_inc); // [RQ19]

	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
			cnt_r <= '0;
		else
			cnt_r <= cnt_nxt;
	end

	AST_PRD_CLEAR: assert property ( // [RQ10]
		@(posedge i_clk) disable iff (!i_rstn)
		lnk.prd_hit && !lnk.clr_sel |=> cnt_r == 16'h0000)
		else $error("period match did not clear the counter");
endmodule // etm_counter

// File: hdl/etm_outpin.sv
// One compare output pin: initial level, match action, polarity.
// Assumes match and load strobes are one-cycle pulses on i_clk.
`timescale 1ns/1ps
module etm_outpin
	import etm_pkg::*;
(
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rstn,
	// Controls
	input wire logic i_load,
	input wire logic i_level_sel,
	input wire logic i_match,
	input wire logic [1:0] i_func,
	input wire logic i_invert,
	input wire logic i_drive,
	// Pin
	output logic o_pin,
	output logic o_oe_n
);
	logic lvl_r;
	logic lvl_nxt;
	wire etm_func_t fn = etm_func_t'(i_func);
	wire logic act = i_drive && i_match;

	always_comb
	begin
		lvl_nxt = lvl_r;
		if (i_load)
			lvl_nxt = i_level_sel; // [RQ14] [RQ1]
		else if (act)
			case (fn) // [RQ13] [RQ17] [RQ15]
				FN_LOW: lvl_nxt = 1'b0;
				FN_HIGH: lvl_nxt = 1'b1;
				FN_TOG: lvl_nxt = !lvl_r;
				default: lvl_nxt = lvl_r;
			endcase
	end

	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			lvl_r <= 1'b0;
			o_pin <= 1'b0;
			o_oe_n <= 1'b1;
		end
		else
		begin
			lvl_r <= lvl_nxt;
			o_pin <= i_drive ? (lvl_nxt ^ i_invert) : 1'b0; // [RQ2] [RQ3]
			o_oe_n <= !i_drive; // [RQ16]
		end
	end

	// Pin was already driven one cycle back, so no enable step is seen
	AST_HOLD_FUNC: assert property ( // [RQ15]
		@(posedge i_clk) disable iff (!i_rstn)
		i_drive && $past(i_drive) && !i_load && (i_func == 2'b00)
		&& $stable(i_invert) ##1 i_drive |-> $stable(o_pin))
		else $error("pin moved with no-change function");
	AST_LOAD_LEVEL: assert property ( // [RQ14]
		@(posedge i_clk) disable iff (!i_rstn)
		i_load && i_drive
		|=> o_pin == ($past(i_level_sel) ^ $past(i_invert)))
		else $error("pin not loaded with initial level");
endmodule // etm_outpin

// File: tb/test_etm_top.sv
// Self-checking bench for the compare match timer top level.
// Assumes the register map and timing of the timer top level.
`timescale 1ns/1ps
module test_etm_top
	import etm_pkg::*;
;
	logic i_clk = 1'b0;
	logic i_rstn = 1'b0;
	logic [AW-1:0] i_addr = '0;
	logic [DW-1:0] i_wdata = '0;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	logic [DW-1:0] o_rdata;
	logic o_irq, o_pin_a, o_pin_a_oe_n, o_pin_b, o_pin_b_oe_n;
	int bad_count = 0;
	int n_checks = 0;
	logic [31:0] rnd = 32'h69DA;
	logic [7:0] rv, rh;
	logic [15:0] ca, cnt;
	logic la, lb, inv;
	time t0, t1, tp;
	int f, a;

	etm_top u_dut (.i_clk(i_clk), .i_rstn(i_rstn), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
		.o_irq(o_irq), .o_pin_a(o_pin_a), .o_pin_a_oe_n(o_pin_a_oe_n),
		.o_pin_b(o_pin_b), .o_pin_b_oe_n(o_pin_b_oe_n));

	always #5 i_clk = ~i_clk;

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	// Pin level after a match for a given function code
	function automatic logic nxt(input int fn, input logic cur);
		case (fn)
			1: return 1'b0;
			2: return 1'b1;
			3: return ~cur;
			default: return cur;
		endcase
	endfunction

	function automatic logic [7:0] aln(input int v);
		case (v)
			0: return 8'h01;
			1: return 8'h02;
			2: return 8'h04;
			default: return 8'h06;
		endcase
	endfunction

	task automatic check(input string nm, input logic [31:0] seen,
		input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
			bad_count++;
		end
	endtask

	task automatic complete_run;
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic wr(input logic [AW-1:0] ad, input logic [DW-1:0] d);
		@(posedge i_clk);
		i_wr <= 1'b1;
		i_addr <= ad;
		i_wdata <= d;
		@(posedge i_clk);
		i_wr <= 1'b0;
		t0 = $time;
	endtask

	task automatic rd(input logic [AW-1:0] ad, output logic [DW-1:0] d);
		@(posedge i_clk);
		i_rd <= 1'b1;
		i_addr <= ad;
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1 d = o_rdata;
	endtask

	task automatic wr16(input logic [AW-1:0] ad, input logic [15:0] v);
		wr(ad, v[7:0]);
		wr(ad + 4'h1, v[15:8]);
	endtask

	task automatic wait_irq(input int n);
		int k;
		for (k = 0; k < n; k++)
		begin
			@(posedge i_clk);
			#1;
			if (o_irq === 1'b1)
				break;
		end
		if (k == n)
		begin
			check("irq wait", 32'h0, 32'h1);
			complete_run();
		end
		t1 = $time - 1;
	endtask

	initial
	begin
		repeat (16) @(posedge i_clk);
		i_rstn <= 1'b1;
		#1;
		check("oe_a reset", o_pin_a_oe_n, 32'h1);
		check("oe_b reset", o_pin_b_oe_n, 32'h1);
		// Reset values, align decode default, unmapped place
		for (a = 0; a < 14; a++)
		begin
			rd(a[3:0], rv);
			check("reset reg", rv, (a == 12) ? 32'h1 : 32'h0);
		end
		wr(4'hE, 8'hFF);
		rd(4'hE, rv);
		check("unmapped", rv, 32'h0);
		rnd = lfsr(rnd);
		wr(OFS_PRD, rnd[7:0]);
		rd(OFS_PRD, rv);
		check("period rw", rv, rnd[7:0]);
		for (f = 0; f < 4; f++)
		begin
			wr(OFS_CTL2, f[7:0]);
			rd(OFS_ALIGN, rv);
			check("align", rv, aln(f));
		end
		// Capture on both channels: direction bit reads zero, pins free
		wr(OFS_CTL1, 8'h42);
		wr(OFS_CTL2, 8'h40);
		rd(OFS_CTL1, rv);
		check("dir read-only", rv, 32'h40);
		check("oe_a inert", o_pin_a_oe_n, 32'h1);
		check("oe_b inert", o_pin_b_oe_n, 32'h1);
		// Compare output mode, cleared by comparator A, every function code
		for (f = 0; f < 4; f++)
		begin
			rnd = lfsr(rnd);
			ca = 16'h0100 + {8'h00, rnd[7:0]};
			la = rnd[8];
			lb = rnd[9];
			inv = rnd[10];
			wr(OFS_RUN, 8'h00);
			wr(OFS_STAT, 8'h07);
			wr(OFS_PRD, 8'h01);
			wr(OFS_CTL1, {2'b00, f[1:0], la, 3'b001});
			wr(OFS_CTL2, {2'b00, 2'(3 - f), lb, inv, 2'b00});
			wr16(OFS_CMPA_L, ca);
			wr16(OFS_CMPB_L, ca - 16'h0008);
			wr(OFS_MASK, 8'h01);
			wr(OFS_RUN, 8'h01);
			repeat (2) @(posedge i_clk);
			#1;
			check("pin_a init", o_pin_a, la);
			check("pin_b init", o_pin_b, lb ^ inv);
			check("oe_a cmp", o_pin_a_oe_n, 32'h0);
			check("oe_b cmp", o_pin_b_oe_n, 32'h0);
			wait_irq(600);
			check("pin_a match", o_pin_a, nxt(f, la));
			check("pin_b match", o_pin_b, nxt(3 - f, lb) ^ inv);
			tp = t1;
			rd(OFS_STAT, rv);
			check("status clr_sel 1", rv, 32'h3);
			wr(OFS_STAT, 8'h07);
			#1;
			check("irq after clear", o_irq, 32'h0);
			wait_irq(600);
			check("a period", (t1 - tp) / 10, ca + 16'h1);
		end
		// Period comparator clears, pins untouched by its match
		wr(OFS_RUN, 8'h00);
		wr(OFS_STAT, 8'h07);
		wr(OFS_CTL1, 8'h08);
		wr(OFS_CTL2, 8'h00);
		wr(OFS_PRD, 8'h02);
		wr16(OFS_CMPA_L, 16'h0080);
		wr16(OFS_CMPB_L, 16'hFFFF);
		wr(OFS_MASK, 8'h04);
		wr(OFS_RUN, 8'h01);
		wait_irq(600);
		tp = t1;
		check("pin_a on p", o_pin_a, 32'h1);
		check("pin_b on p", o_pin_b, 32'h0);
		rd(OFS_STAT, rv);
		check("status clr_sel 0", rv, 32'h5);
		wr(OFS_STAT, 8'h07);
		wait_irq(600);
		check("p period", (t1 - tp) / 10, 32'd512);
		// Timer mode with zero period: overflow, no pins driven
		wr(OFS_RUN, 8'h00);
		rd(OFS_CNT_L, rv);
		rd(OFS_CNT_H, rh);
		cnt = {rh, rv};
		wr(OFS_STAT, 8'h07);
		wr(OFS_CTL1, 8'hFC);
		wr(OFS_CTL2, 8'hFC);
		wr(OFS_PRD, 8'h00);
		wr(OFS_MASK, 8'h06);
		wr(OFS_RUN, 8'h01);
		tp = t0;
		repeat (2) @(posedge i_clk);
		#1;
		check("oe_a timer", o_pin_a_oe_n, 32'h1);
		check("oe_b timer", o_pin_b_oe_n, 32'h1);
		wait_irq(70000);
		check("overflow", (t1 - tp) / 10, 32'd65536 - cnt);
		check("pin_a timer", o_pin_a, 32'h0);
		check("pin_b timer", o_pin_b, 32'h0);
		rd(OFS_STAT, rv);
		check("status timer", rv, 32'h7);
		complete_run();
	end
endmodule // test_etm_top
